// File: hdl/src_pkg.sv
// package of constants and types for the s-record decoder
package src_pkg;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [1:0] PH_HIGH = 2'h0;
    localparam logic [1:0] PH_LOW = 2'h1;

    // record event kinds presented on the output
    typedef enum logic [2:0] {
        EV_HEADER = 3'h0,
        EV_DATA = 3'h1,
        EV_COUNT = 3'h2,
        EV_TERM = 3'h3
    } src_ev_t;

    // decoder states, one-hot
    typedef enum logic [6:0] {
        ST_HUNT = 7'h01,
        ST_TYPE = 7'h02,
        ST_COUNT = 7'h04,
        ST_ADDR = 7'h08,
        ST_DATA = 7'h10,
        ST_SUM = 7'h20,
        ST_SKIP = 7'h40
    } src_state_t;

    // decoded byte stream toward the loader
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] data;
        logic [3:0] rtype;
    } src_byte_t;

    // record-end report
    typedef struct packed {
        src_ev_t kind;
        logic [3:0] rtype;
        logic [31:0] addr;
        logic [7:0] count;
        logic ok;
    } src_rec_t;
endpackage

// File: hdl/src_fifo.sv
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module src_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } src_fst_t;
    src_fst_t st;
    src_fst_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign in_ready = st.cnt != (AW+1)'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data = mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage write
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule

// File: hdl/src_decoder.sv
// s-record character stream decoder with byte FIFO on the output
`timescale 1ns/100ps
module src_decoder (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // ascii character input
    input wire logic char_valid,
    output logic char_ready,
    input wire logic [7:0] char_data,
    // decoded payload bytes
    output logic byte_valid,
    input wire logic byte_ready,
    output src_pkg::src_byte_t byte_out,
    // record-end report
    output logic rec_valid,
    output src_pkg::src_rec_t rec_out,
    output logic err_flag
);
    import src_pkg::*;

    typedef struct packed {
        src_state_t state;
        logic [3:0] rtype;
        logic [7:0] count;
        logic [7:0] left;
        logic [2:0] alen;
        logic [2:0] aleft;
        logic [31:0] addr;
        logic [31:0] waddr;
        logic [7:0] sum;
        logic [3:0] hi;
        logic phase;
        logic bad;
        logic f_valid;
        src_byte_t f_data;
        logic rec_valid;
        src_rec_t rec;
        logic err;
        logic char_ready;
        logic o_valid;
        src_byte_t o_data;
    } src_st_t;

    src_st_t st;
    src_st_t next_st;
    logic f_ready;
    logic f_out_valid;
    logic [43:0] f_out_data;
    logic take;
    logic f_take;

    // ascii hex digit to nibble, flag clear for non-hex
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            hex_val = {1'b1, 4'(c - 8'h30)};
        end else if (c >= 8'h41 && c <= 8'h46) begin
            hex_val = {1'b1, 4'(c - 8'h37)};
        end else if (c >= 8'h61 && c <= 8'h66) begin
            hex_val = {1'b1, 4'(c - 8'h57)};
        end else begin
            hex_val = 5'h00;
        end
    endfunction

    // address length per type; 0 means an unsupported type
    function automatic logic [2:0] addr_len(input logic [3:0] t);
        case (t)
            4'h0, 4'h1, 4'h5, 4'h9: addr_len = 3'h2;
            4'h2, 4'h8: addr_len = 3'h3;
            4'h3, 4'h7: addr_len = 3'h4;
            default: addr_len = 3'h0;
        endcase
    endfunction

    function automatic logic is_term(input logic [3:0] t);
        is_term = (t == 4'h7) || (t == 4'h8) || (t == 4'h9);
    endfunction

    function automatic logic is_line_end(input logic [7:0] c);
        is_line_end = (c == CH_CR) || (c == CH_LF) || (c == CH_NUL);
    endfunction

    assign take = char_valid && st.char_ready;
    assign char_ready = st.char_ready;
    // output stage may refill when empty or when its byte leaves this cycle
    assign f_take = !st.o_valid || byte_ready;

    // decode one character per accepted input
    always_comb begin
        logic [4:0] hv;
        logic [7:0] b;
        logic [7:0] nsum;
        hv = hex_val(char_data);
        b = {st.hi, hv[3:0]};
        nsum = st.sum + b;
        next_st = st;
        next_st.rec_valid = 1'b0;
        next_st.err = 1'b0;
        // registered output stage keeps the byte port straight off flip-flops
        if (f_take) begin
            next_st.o_valid = f_out_valid;
            if (f_out_valid) begin
                next_st.o_data = f_out_data;
            end
        end
        if (st.f_valid && f_ready) begin
            next_st.f_valid = 1'b0;
        end
        next_st.char_ready = !next_st.f_valid;
        if (take) begin
            next_st.char_ready = 1'b0;
            case (st.state)
                ST_HUNT: begin
                    // leading fields and terminators are dropped
                    if (char_data == CH_S) begin
                        next_st.state = ST_TYPE;
                    end
                end
                ST_TYPE: begin
                    // type digit selects the address width
                    if (hv[4] && addr_len(hv[3:0]) != 3'h0) begin
                        next_st.rtype = hv[3:0];
                        next_st.alen = addr_len(hv[3:0]);
                        next_st.aleft = addr_len(hv[3:0]);
                        next_st.state = ST_COUNT;
                        next_st.phase = PH_HIGH[0];
                        next_st.sum = 8'h00;
                        next_st.addr = 32'h0000_0000;
                    end else begin
                        next_st.err = 1'b1;
                        next_st.state = ST_SKIP;
                    end
                end
                ST_COUNT, ST_ADDR, ST_DATA, ST_SUM: begin
                    if (!hv[4]) begin
                        next_st.err = 1'b1;
                        next_st.state = is_line_end(char_data) ? ST_HUNT : ST_SKIP;
                    end else if (st.phase == PH_HIGH[0]) begin
                        next_st.hi = hv[3:0];
                        next_st.phase = PH_LOW[0];
                    end else begin
                        next_st.phase = PH_HIGH[0];
                        next_st.sum = nsum;
                        next_st.left = st.left - 8'h01;
                        case (st.state)
                            ST_COUNT: begin
                                // count covers address, payload and checksum
                                next_st.count = b;
                                next_st.left = b;
                                next_st.state = ST_ADDR;
                                if (b < 8'(st.alen) + 8'h01) begin
                                    next_st.err = 1'b1;
                                    next_st.state = ST_SKIP;
                                end
                            end
                            ST_ADDR: begin
                                next_st.addr = {st.addr[23:0], b};
                                next_st.aleft = st.aleft - 3'h1;
                                if (st.aleft == 3'h1) begin
                                    next_st.waddr = {st.addr[23:0], b};
                                    next_st.state = (st.left == 8'h02) ? ST_SUM : ST_DATA;
                                end
                            end
                            ST_DATA: begin
                                // only load records feed the loader; header text is dropped
                                if (st.rtype inside {4'h1, 4'h2, 4'h3}) begin
                                    next_st.f_valid = 1'b1;
                                    next_st.f_data.addr = st.waddr;
                                    next_st.f_data.data = b;
                                    next_st.f_data.rtype = st.rtype;
                                end
                                next_st.waddr = st.waddr + 32'h0000_0001;
                                next_st.char_ready = 1'b0;
                                if (st.left == 8'h02) begin
                                    next_st.state = ST_SUM;
                                end
                            end
                            default: begin
                                // checksum: all bytes plus sum must give FF
                                next_st.state = ST_HUNT;
                                next_st.rec_valid = 1'b1;
                                next_st.rec.rtype = st.rtype;
                                next_st.rec.addr = st.addr;
                                next_st.rec.count = st.count;
                                next_st.rec.ok = (nsum == 8'hFF);
                                next_st.err = (nsum != 8'hFF);
                                if (st.rtype == 4'h0) begin
                                    next_st.rec.kind = EV_HEADER;
                                end else if (st.rtype == 4'h5) begin
                                    next_st.rec.kind = EV_COUNT;
                                end else if (is_term(st.rtype)) begin
                                    next_st.rec.kind = EV_TERM;
                                end else begin
                                    next_st.rec.kind = EV_DATA;
                                end
                            end
                        endcase
                    end
                end
                ST_SKIP: begin
                    // discard rest of a bad record up to its line end
                    if (is_line_end(char_data)) begin
                        next_st.state = ST_HUNT;
                    end
                end
                default: begin
                    next_st.state = ST_HUNT;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.state <= ST_HUNT;
        end else begin
            st <= next_st;
        end
    end

    // payload bytes queue here, stalling the character input when full
    src_fifo #(
        .WIDTH(44),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(st.f_valid),
        .in_ready(f_ready),
        .in_data(st.f_data),
        .out_valid(f_out_valid),
        .out_ready(f_take),
        .out_data(f_out_data)
    );

    // outputs
    assign byte_valid = st.o_valid;
    assign byte_out = st.o_data;
    assign rec_valid = st.rec_valid;
    assign rec_out = st.rec;
    assign err_flag = st.err;
endmodule

// File: verification/src_decoder_sva.sv
// port checker for the s-record decoder
`timescale 1ns/100ps
module src_decoder_sva
    import src_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // character side
    input wire logic char_valid,
    input wire logic char_ready,
    input wire logic [7:0] char_data,
    // byte and record side
    input wire logic byte_valid,
    input wire logic byte_ready,
    input wire src_pkg::src_byte_t byte_out,
    input wire logic rec_valid,
    input wire src_pkg::src_rec_t rec_out,
    input wire logic err_flag
);
    logic take;
    // a character changes hands
    assign take = char_valid && char_ready;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_ready_gap: assert property (take |=> !char_ready)
        else $error("char_ready high right after a take");
    a_rec_pulse: assert property (rec_valid |=> !rec_valid)
        else $error("rec_valid longer than one cycle");
    a_err_pulse: assert property (err_flag |=> !err_flag)
        else $error("err_flag longer than one cycle");
    a_byte_hold: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_out))
        else $error("byte dropped or changed while stalled");
    a_bad_sum: assert property (rec_valid && !rec_out.ok |-> err_flag)
        else $error("failed record without error flag");
    a_good_quiet: assert property (rec_valid && rec_out.ok |-> !err_flag)
        else $error("error flag on a good record");
    a_kind_match: assert property (rec_valid |-> rec_out.kind ==
        ((rec_out.rtype == 4'h0) ? EV_HEADER : (rec_out.rtype == 4'h5) ? EV_COUNT :
        (rec_out.rtype > 4'h6) ? EV_TERM : EV_DATA))
        else $error("record kind does not fit its type");
    a_rec_cause: assert property (rec_valid |-> $past(take) || $past(take, 2))
        else $error("record end without a recent character");
    a_load_types: assert property (byte_valid |-> byte_out.rtype inside {4'h1, 4'h2, 4'h3})
        else $error("byte queued from a non-loading record");

    c_term: cover property (rec_valid && rec_out.ok && rec_out.kind == EV_TERM);
    c_bad: cover property (rec_valid && !rec_out.ok);
    c_full: cover property (byte_valid && !byte_ready && !char_ready);
endmodule

// File: verification/src_host.sv
// host model offering ascii characters with valid/ready
`timescale 1ns/100ps
module src_host (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pacing
    input wire logic slow,
    // character link
    input wire logic char_ready,
    output logic char_valid,
    output logic [7:0] char_data
);
    logic [7:0] q[$];
    logic took;
    initial begin
        char_valid = 1'b0;
        char_data = 8'hFF;
    end
    // hold a character until taken; idle data keeps changing, never stale
    always @(posedge core_clk) begin
        took = char_valid && char_ready;
        #1;
        if (took) begin
            char_valid = 1'b0;
            char_data = ~char_data;
        end else if (!char_valid && !rst && q.size() > 0 && !(slow && $urandom_range(1, 0) == 0)) begin
            char_data = q.pop_front();
            char_valid = 1'b1;
        end else if (!char_valid) begin
            char_data = ~char_data;
        end
    end
endmodule

// File: verification/tb_srecord_codec.sv
// self-checking bench for the s-record decoder
`timescale 1ns/100ps
module tb_srecord_codec;
    import src_pkg::*;
    logic core_clk, rst, char_valid, char_ready, byte_valid, byte_ready;
    logic rec_valid, err_flag, slow, stall;
    logic [7:0] char_data;
    logic [3:0] types[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9};
    src_byte_t byte_out;
    src_rec_t rec_out;
    src_rec_t rq[$];
    src_byte_t bq[$];
    int miscompares, checks, cycles, n_err, exp_err;

    src_decoder i_dut (.core_clk(core_clk), .rst(rst), .char_valid(char_valid),
        .char_ready(char_ready), .char_data(char_data), .byte_valid(byte_valid),
        .byte_ready(byte_ready), .byte_out(byte_out), .rec_valid(rec_valid),
        .rec_out(rec_out), .err_flag(err_flag));
    src_host i_host (.core_clk(core_clk), .rst(rst), .slow(slow), .char_ready(char_ready),
        .char_valid(char_valid), .char_data(char_data));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic src_ev_t kind(input logic [3:0] t);
        return (t == 4'h0) ? EV_HEADER : (t == 4'h5) ? EV_COUNT : (t > 4'h6) ? EV_TERM : EV_DATA;
    endfunction

    // queue a string, then CR LF NUL
    task automatic push(input string s);
        foreach (s[i]) i_host.q.push_back(s[i]);
        i_host.q.push_back(CH_CR);
        i_host.q.push_back(CH_LF);
        i_host.q.push_back(CH_NUL);
    endtask

    // mode 0 good, 1 bad checksum, 2 non-hex in address
    task automatic send_rec(input logic [3:0] t, input logic [31:0] a, input int n, input int mode);
        string s;
        logic [7:0] b, sum;
        int al, pos;
        al = (t == 4'h2 || t == 4'h8) ? 3 : (t == 4'h3 || t == 4'h7) ? 4 : 2;
        if (al < 4) a = a & ((32'h1 << (8 * al)) - 32'h1);
        s = $sformatf("%0d S%0h", $urandom_range(99, 0), t);
        sum = 8'(al + n + 1);
        s = {s, $sformatf("%02X", sum)};
        pos = s.len();
        for (int i = al - 1; i >= 0; i--) begin
            sum += a[8 * i +: 8];
            s = {s, $sformatf("%02X", a[8 * i +: 8])};
        end
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            sum += b;
            s = {s, $sformatf("%02x", b)};
            if (mode != 2 && t inside {4'h1, 4'h2, 4'h3}) begin
                bq.push_back(src_byte_t'{a + 32'(i), b, t});
            end
        end
        s = {s, $sformatf("%02X", (mode == 1) ? ~sum ^ 8'h01 : ~sum)};
        if (mode == 2) s.putc(pos, "G");
        if (mode != 2) rq.push_back(src_rec_t'{kind(t), t, a, 8'(al + n + 1), mode == 0});
        if (mode != 0) exp_err++;
        push(s);
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 3000 && i_host.q.size() > 0; k++) @(posedge core_clk);
        repeat (40) @(posedge core_clk);
    endtask

    // record, byte and error monitors
    always @(posedge core_clk) begin
        if (!rst && rec_valid) begin
            if (rq.size() == 0) check("extra record", 1, 0);
            else check("record", rec_out, rq.pop_front());
        end
        if (!rst && byte_valid && byte_ready) begin
            if (bq.size() == 0) check("extra byte", 1, 0);
            else check("byte", byte_out, bq.pop_front());
        end
        if (!rst && err_flag) n_err++;
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // drain side stalls at random
    always @(posedge core_clk) begin
        #1;
        byte_ready = !stall && $urandom_range(3, 0) != 0;
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(17));
        rst = 1'b1;
        slow = 1'b0;
        stall = 1'b0;
        byte_ready = 1'b0;
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        for (int p = 0; p < 3; p++) begin
            foreach (types[j]) begin
                slow = $urandom_range(1, 0);
                send_rec(types[j], $urandom, (types[j] > 4'h3) ? 0 : (p == 0) ? 0 :
                    (p == 1) ? 28 : $urandom_range(27, 1), 0);
                wait_idle();
            end
        end
        send_rec(4'h1, $urandom, 4, 1);
        send_rec(4'h2, $urandom, 3, 2);
        push("S403000000FC");
        push("S603000000FC");
        push("S1020000FD");
        exp_err += 3;
        wait_idle();
        stall = 1'b1;
        send_rec(4'h1, $urandom, 28, 0);
        repeat (400) @(posedge core_clk);
        // look once the edge's updates have settled
        #2;
        check("char_ready while full", char_ready, 0);
        check("byte_valid while full", byte_valid, 1);
        stall = 1'b0;
        wait_idle();
        check("records left", rq.size(), 0);
        check("bytes left", bq.size(), 0);
        check("error pulses", n_err, exp_err);
        wrap_up();
    end
endmodule

bind src_decoder src_decoder_sva i_sva (.core_clk(core_clk), .rst(rst), .char_valid(char_valid),
    .char_ready(char_ready), .char_data(char_data), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .byte_out(byte_out), .rec_valid(rec_valid), .rec_out(rec_out),
    .err_flag(err_flag));
